// >>> core/tmr_regs_alert.sv
// Register file, limit flags and alert latch of the two-channel monitor
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_regs_alert #(
  parameter int unsigned BASE_CYC =
    `TMR_BASE_PERIOD_MS * `TMR_NS_PER_MS / `TMR_CLK_PERIOD_NS,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Byte port from the serial slave engine
  input wire logic wr_req_in,
  input wire logic wr_first_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic alert_resp_in,
  // Measurement front end
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire tmr_pkg::tmr_meas_t meas_in,
  // Pins
  input wire logic sleep_request_pin_n_in,
  output logic alert_n_out,
  output logic alert_oe_out
);
  logic rst_q1;
  logic rst_n;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_level;
  logic [7:0] register_pointer;
  logic [7:0] local_temp_value;
  logic [7:0] remote_temp_value_hi;
  logic [7:0] remote_temp_value_lo;
  logic [7:0] device_control;
  logic [7:0] sample_rate_select;
  logic [7:0] local_upper_limit;
  logic [7:0] local_lower_limit;
  logic [7:0] remote_upper_limit_hi;
  logic [7:0] remote_lower_limit_hi;
  logic [7:0] remote_upper_limit_lo;
  logic [7:0] remote_lower_limit_lo;
  logic [7:0] remote_trim_hi;
  logic [7:0] remote_trim_lo;
  logic open_cond;
  logic alert_latch;
  logic oneshot_active;
  logic rate_tick;
  logic sleep;
  logic oneshot_wr;
  logic result_take;
  logic status_rd;
  logic [10:0] rem_adj;
  logic [10:0] rem_val;
  logic [10:0] rem_up;
  logic [10:0] rem_low;
  logic [7:0] status_word;
  logic [7:0] rd_mux;
  tmr_pkg::tmr_conv_state_t conv_state;
  tmr_pkg::tmr_flags_t alarm_flags;
  tmr_pkg::tmr_flags_t cond_now;

  // Register data write: pointer already loaded and address matches
  function automatic logic wr_hit(input logic [7:0] addr);
    return wr_req_in && !wr_first_in && (register_pointer == addr);
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Standby pin: a change counts only once two stages agree
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= sleep_request_pin_n_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  assign sleep = device_control[`TMR_CTRL_SLEEP_BIT] || !pin_level;
  // Written out so the assign follows the bus signals, not only its argument
  assign oneshot_wr = wr_req_in && !wr_first_in && (register_pointer == `TMR_WR_ONESHOT);
  assign status_rd = rd_req_in && (register_pointer == `TMR_RD_STATUS);

  // Pointer takes the first byte of every write
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      register_pointer <= `TMR_RST_ZERO;
    end else if (wr_req_in && wr_first_in) begin
      register_pointer <= wr_data_in;
    end
  end

  // Control, rate and trim registers at their write addresses
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      device_control <= `TMR_RST_CTRL;
      sample_rate_select <= `TMR_RST_RATE;
      remote_trim_hi <= `TMR_RST_ZERO;
      remote_trim_lo <= `TMR_RST_ZERO;
    end else begin
      if (wr_hit(`TMR_WR_CTRL)) device_control <= wr_data_in;
      if (wr_hit(`TMR_WR_RATE)) sample_rate_select <= wr_data_in;
      if (wr_hit(`TMR_RW_TRIM_HI)) remote_trim_hi <= wr_data_in;
      if (wr_hit(`TMR_RW_TRIM_LO)) remote_trim_lo <= wr_data_in;
    end
  end

  // Limit registers
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      local_upper_limit <= `TMR_RST_UP;
      local_lower_limit <= `TMR_RST_LO;
      remote_upper_limit_hi <= `TMR_RST_UP;
      remote_lower_limit_hi <= `TMR_RST_LO;
      remote_upper_limit_lo <= `TMR_RST_ZERO;
      remote_lower_limit_lo <= `TMR_RST_ZERO;
    end else begin
      if (wr_hit(`TMR_WR_LOC_UP)) local_upper_limit <= wr_data_in;
      if (wr_hit(`TMR_WR_LOC_LO)) local_lower_limit <= wr_data_in;
      if (wr_hit(`TMR_WR_REM_UP)) remote_upper_limit_hi <= wr_data_in;
      if (wr_hit(`TMR_WR_REM_LO)) remote_lower_limit_hi <= wr_data_in;
      if (wr_hit(`TMR_RW_REM_UP_LO)) remote_upper_limit_lo <= wr_data_in;
      if (wr_hit(`TMR_RW_REM_LO_LO)) remote_lower_limit_lo <= wr_data_in;
    end
  end

  tmr_rate_div #(
    .BASE_CYC(BASE_CYC)
  ) u_rate_div (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .rate_in(sample_rate_select[`TMR_RATE_MSB:0]),
    .tick_out(rate_tick)
  );

  // Raw remote result is unsigned, so nothing below zero is measured
  tmr_remote_adj u_remote_adj (
    .raw_in(meas_in.remote_raw),
    .trim_hi_in(remote_trim_hi),
    .trim_lo_in(remote_trim_lo),
    .value_out(rem_adj)
  );

  // A one-shot goes ahead even in standby; in run it only adds a cycle
  assign conv_start_out = (conv_state == tmr_pkg::tmr_idle) &&
                          (oneshot_wr || (rate_tick && !sleep));

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_state <= tmr_pkg::tmr_idle;
      oneshot_active <= 1'b0;
    end else begin
      case (conv_state)
        tmr_pkg::tmr_idle: begin
          if (conv_start_out) begin
            conv_state <= tmr_pkg::tmr_conv;
            oneshot_active <= oneshot_wr;
          end
        end
        tmr_pkg::tmr_conv: begin
          if (conv_done_in) begin
            conv_state <= tmr_pkg::tmr_idle;
            oneshot_active <= 1'b0;
          end
        end
        default: begin
          conv_state <= tmr_pkg::tmr_idle;
        end
      endcase
    end
  end

  // A rate-tick conversion caught by standby entry is dropped so values stay frozen; a one-shot result is kept
  assign result_take = (conv_state == tmr_pkg::tmr_conv) && conv_done_in &&
                       (!sleep || oneshot_active);

  // Value registers: converter only, bus writes never land here
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      local_temp_value <= `TMR_RST_TEMP;
      remote_temp_value_hi <= `TMR_RST_TEMP;
      remote_temp_value_lo <= `TMR_RST_ZERO;
      open_cond <= 1'b0;
    end else if (result_take) begin
      local_temp_value <= {1'b0, meas_in.local_raw};
      remote_temp_value_hi <= rem_adj[10:`TMR_FRAC_W];
      remote_temp_value_lo <= {rem_adj[`TMR_FRAC_W-1:0], `TMR_FRAC_PAD};
      open_cond <= meas_in.open_circuit;
    end
  end

  assign rem_val = {remote_temp_value_hi, remote_temp_value_lo[`TMR_FRAC_MSB -: `TMR_FRAC_W]};
  assign rem_up = {remote_upper_limit_hi, remote_upper_limit_lo[`TMR_FRAC_MSB -: `TMR_FRAC_W]};
  assign rem_low = {remote_lower_limit_hi, remote_lower_limit_lo[`TMR_FRAC_MSB -: `TMR_FRAC_W]};

  // Comparators run on the held values, so power-up in standby trips low flags
  always_comb begin
    cond_now.local_over_flag = $signed(local_temp_value) > $signed(local_upper_limit);
    cond_now.local_under_flag = $signed(local_temp_value) < $signed(local_lower_limit);
    cond_now.remote_over_flag = $signed(rem_val) > $signed(rem_up);
    cond_now.remote_under_flag = $signed(rem_val) < $signed(rem_low);
    cond_now.open_flag = open_cond;
  end

  // Set wins over the read clear; a live cause keeps its flag
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flags <= '0;
    end else if (status_rd) begin
      alarm_flags <= cond_now;
    end else begin
      alarm_flags <= tmr_pkg::tmr_flags_t'(alarm_flags | cond_now);
    end
  end

  // Alert latch: only the alert response read lets it go
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      alert_latch <= 1'b0;
    end else if (|alarm_flags) begin
      alert_latch <= 1'b1;
    end else if (alert_resp_in && !(|cond_now)) begin
      alert_latch <= 1'b0;
    end
  end

  // Open-drain alert: enable high while pulling the line low
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      alert_oe_out <= 1'b0;
      alert_n_out <= 1'b1;
    end else begin
      alert_oe_out <= alert_latch && !device_control[`TMR_CTRL_MASK_BIT];
      alert_n_out <= !(alert_latch && !device_control[`TMR_CTRL_MASK_BIT]);
    end
  end

  assign status_word = {conv_state == tmr_pkg::tmr_conv, alarm_flags, 2'b00};

  // Write-only and unmapped read addresses return zero
  always_comb begin
    case (register_pointer)
      `TMR_RD_LOCAL: rd_mux = local_temp_value;
      `TMR_RD_REM_HI: rd_mux = remote_temp_value_hi;
      `TMR_RD_STATUS: rd_mux = status_word;
      `TMR_RD_CTRL: rd_mux = device_control;
      `TMR_RD_RATE: rd_mux = sample_rate_select;
      `TMR_RD_LOC_UP: rd_mux = local_upper_limit;
      `TMR_RD_LOC_LO: rd_mux = local_lower_limit;
      `TMR_RD_REM_UP: rd_mux = remote_upper_limit_hi;
      `TMR_RD_REM_LO: rd_mux = remote_lower_limit_hi;
      `TMR_RD_REM_FRAC: rd_mux = remote_temp_value_lo;
      `TMR_RW_TRIM_HI: rd_mux = remote_trim_hi;
      `TMR_RW_TRIM_LO: rd_mux = remote_trim_lo;
      `TMR_RW_REM_UP_LO: rd_mux = remote_upper_limit_lo;
      `TMR_RW_REM_LO_LO: rd_mux = remote_lower_limit_lo;
      `TMR_RD_RSVD_A: rd_mux = `TMR_RST_ZERO;
      `TMR_RD_MAKER: rd_mux = MAKER_ID;
      `TMR_RD_REV: rd_mux = REVISION_ID;
      default: rd_mux = `TMR_RST_ZERO;
    endcase
  end

  // Read data is captured before a status clear takes effect
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out <= `TMR_RST_ZERO;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_req_in;
      if (rd_req_in) rd_data_out <= rd_mux;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  ptr_load_a: assert property (
    wr_req_in && wr_first_in |=> register_pointer == $past(wr_data_in))
    else $error("pointer did not take first write byte");
  busy_set_a: assert property (
    conv_start_out |=> status_word[7])
    else $error("busy not set after conversion start");
  busy_clear_a: assert property (
    conv_state == tmr_pkg::tmr_conv && conv_done_in |=> !status_word[7])
    else $error("busy not cleared after conversion end");
  oneshot_go_a: assert property (
    oneshot_wr && conv_state == tmr_pkg::tmr_idle |=> conv_state == tmr_pkg::tmr_conv)
    else $error("one-shot write did not start conversion");
  sleep_hold_a: assert property (
    sleep && !oneshot_wr |-> !conv_start_out)
    else $error("conversion started in standby");
  value_ro_a: assert property (
    !result_take |=> $stable(local_temp_value) && $stable(remote_temp_value_hi))
    else $error("value register changed without a result");
  flag_stick_a: assert property (
    status_rd && cond_now.local_over_flag |=> alarm_flags.local_over_flag)
    else $error("live flag cleared by status read");
  latch_set_a: assert property (
    |alarm_flags |=> alert_latch ##1 (alert_oe_out || $past(device_control[`TMR_CTRL_MASK_BIT])))
    else $error("alert latch not set by flag");
  mask_off_a: assert property (
    device_control[`TMR_CTRL_MASK_BIT] |=> !alert_oe_out && alert_n_out)
    else $error("masked alert still driven");
  latch_keep_a: assert property (
    alert_latch && !alert_resp_in |=> alert_latch)
    else $error("alert latch dropped without response read");
  strict_hi_a: assert property (
    local_temp_value == local_upper_limit |-> !cond_now.local_over_flag)
    else $error("equal value tripped high limit");
endmodule // tmr_regs_alert
`default_nettype wire

// >>> core/tmr_defs.svh
// Register addresses, reset values, field positions and timing of the monitor
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_RD_LOCAL 8'h00
`define TMR_RD_REM_HI 8'h01
`define TMR_RD_STATUS 8'h02
`define TMR_RD_CTRL 8'h03
`define TMR_RD_RATE 8'h04
`define TMR_RD_LOC_UP 8'h05
`define TMR_RD_LOC_LO 8'h06
`define TMR_RD_REM_UP 8'h07
`define TMR_RD_REM_LO 8'h08
`define TMR_WR_CTRL 8'h09
`define TMR_WR_RATE 8'h0A
`define TMR_WR_LOC_UP 8'h0B
`define TMR_WR_LOC_LO 8'h0C
`define TMR_WR_REM_UP 8'h0D
`define TMR_WR_REM_LO 8'h0E
`define TMR_WR_ONESHOT 8'h0F
`define TMR_RD_REM_FRAC 8'h10
`define TMR_RW_TRIM_HI 8'h11
`define TMR_RW_TRIM_LO 8'h12
`define TMR_RW_REM_UP_LO 8'h13
`define TMR_RW_REM_LO_LO 8'h14
`define TMR_RD_RSVD_A 8'h19
`define TMR_RD_MAKER 8'hFE
`define TMR_RD_REV 8'hFF
`define TMR_RST_TEMP 8'h80
`define TMR_RST_UP 8'h7F
`define TMR_RST_LO 8'hC9
`define TMR_RST_CTRL 8'h00
`define TMR_RST_RATE 8'h02
`define TMR_RST_ZERO 8'h00
`define TMR_CTRL_MASK_BIT 7
`define TMR_CTRL_SLEEP_BIT 6
`define TMR_RATE_MSB 2
`define TMR_RATE_MAX 3'h7
`define TMR_FRAC_MSB 7
`define TMR_FRAC_W 3
`define TMR_FRAC_PAD 5'h00
`define TMR_BASE_PERIOD_MS 125
`define TMR_CLK_PERIOD_NS 25
`define TMR_NS_PER_MS 1000000
`endif

// >>> core/tmr_pkg.sv
// Types shared by the temperature monitor register and alert logic
package tmr_pkg;
  typedef enum logic {tmr_idle, tmr_conv} tmr_conv_state_t;
  typedef struct packed {
    logic open_circuit;
    logic [6:0] local_raw;
    logic [9:0] remote_raw;
  } tmr_meas_t;
  typedef struct packed {
    logic local_over_flag;
    logic local_under_flag;
    logic remote_over_flag;
    logic remote_under_flag;
    logic open_flag;
  } tmr_flags_t;
endpackage

// >>> core/tmr_rate_div.sv
// Conversion rate divider producing one tick per conversion period
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_rate_div #(
  parameter int unsigned BASE_CYC = 5000000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Rate code and tick
  input wire logic [2:0] rate_in,
  output logic tick_out
);
  logic [31:0] count;

  // Code 7 is the base period, each lower code doubles it
  function automatic logic [31:0] period_cyc(input logic [2:0] code);
    return 32'(BASE_CYC << (`TMR_RATE_MAX - code));
  endfunction

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 32'h0;
      tick_out <= 1'b0;
    end else if (count >= period_cyc(rate_in) - 32'h1) begin
      count <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule // tmr_rate_div
`default_nettype wire

// >>> core/tmr_remote_adj.sv
// Remote result plus signed trim, clamped at the signed extremes
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_remote_adj (
  // Raw result and trim
  input wire logic [9:0] raw_in,
  input wire logic [7:0] trim_hi_in,
  input wire logic [7:0] trim_lo_in,
  // Adjusted 11-bit value
  output logic [10:0] value_out
);
  logic [10:0] trim;

  // Overflow shows as disagreement of the two top sum bits
  function automatic logic [10:0] sat_add(input logic [9:0] raw, input logic [10:0] off);
    logic [11:0] sum;
    sum = {2'b00, raw} + {off[10], off};
    if (!sum[11] && sum[10]) return 11'h3FF;
    if (sum[11] && !sum[10]) return 11'h400;
    return sum[10:0];
  endfunction

  assign trim = {trim_hi_in, trim_lo_in[`TMR_FRAC_MSB -: `TMR_FRAC_W]};
  assign value_out = sat_add(raw_in, trim);
endmodule // tmr_remote_adj
`default_nettype wire

// >>> bench/tmr_host.sv
// Bus-master model issuing pointer loads, byte writes, reads and alert responses
`timescale 1ns/1ps
`default_nettype none
module tmr_host (
  // Clock
  input wire logic clk_in,
  // Byte port towards the register file
  output logic wr_req_out,
  output logic wr_first_out,
  output logic [7:0] wr_data_out,
  output logic rd_req_out,
  output logic alert_resp_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    wr_req_out = 1'b0;
    wr_first_out = 1'b0;
    wr_data_out = 8'h00;
    rd_req_out = 1'b0;
    alert_resp_out = 1'b0;
  end
  task automatic setp(input logic [7:0] a);
    @(posedge clk_in);
    wr_req_out <= 1'b1;
    wr_first_out <= 1'b1;
    wr_data_out <= a;
    @(posedge clk_in);
    wr_req_out <= 1'b0;
    wr_first_out <= 1'b0;
    wr_data_out <= ~a;
  endtask
  // Reserved space above the map is never written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a <= 8'h14) begin
      @(posedge clk_in);
      wr_req_out <= 1'b1;
      wr_first_out <= 1'b1;
      wr_data_out <= a;
      @(posedge clk_in);
      wr_first_out <= 1'b0;
      wr_data_out <= d;
      @(posedge clk_in);
      wr_req_out <= 1'b0;
      wr_data_out <= ~d;
    end
  endtask
  task automatic rd(output logic [7:0] d);
    int n;
    @(posedge clk_in);
    rd_req_out <= 1'b1;
    @(posedge clk_in);
    rd_req_out <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rd_valid_in !== 1'b1 && n < 8);
    // A missing answer reads as unknown so the compare fails
    d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hXX;
  endtask
  task automatic resp();
    @(posedge clk_in);
    alert_resp_out <= 1'b1;
    @(posedge clk_in);
    alert_resp_out <= 1'b0;
  endtask
endmodule // tmr_host
`default_nettype wire

// >>> bench/tmr_regs_alert_test.sv
// Self-checking bench of the monitor register file and alert latch
`timescale 1ns/1ps
`default_nettype none
module tmr_regs_alert_test;
  localparam int BC = 20;
  localparam int D = 12;
  localparam logic [7:0] MID = 8'hA6; // Arbitrary value
  localparam logic [7:0] REV = 8'h12; // Arbitrary value
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr_req_in, wr_first_in, rd_req_in, alert_resp_in, rd_valid_out;
  logic [7:0] wr_data_in, rd_data_out, d, th, tl;
  logic conv_start_out, alert_n_out, alert_oe_out;
  logic conv_done_in = 1'b0;
  logic sleep_request_pin_n_in = 1'b1;
  tmr_pkg::tmr_meas_t meas_in = '0;
  logic [9:0] rr;
  logic [10:0] r11, lim;
  logic [7:0] ex [256];
  logic [4:0] mf = 5'h00;
  logic mal = 1'b0;
  logic op = 1'b0;
  int bad_count = 0, n_checks = 0, cyc = 0, fe_cnt = 0, starts = 0, st, s, n;
  logic [7:0] wl [9] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h13, 8'h14};
  logic [7:0] rl [9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14};
  always #12.5 core_clk_in = ~core_clk_in;
  tmr_regs_alert #(.BASE_CYC(BC), .MAKER_ID(MID), .REVISION_ID(REV)) tmr_regs_alert_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .wr_req_in(wr_req_in),
    .wr_first_in(wr_first_in), .wr_data_in(wr_data_in), .rd_req_in(rd_req_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .alert_resp_in(alert_resp_in),
    .conv_start_out(conv_start_out), .conv_done_in(conv_done_in), .meas_in(meas_in),
    .sleep_request_pin_n_in(sleep_request_pin_n_in), .alert_n_out(alert_n_out),
    .alert_oe_out(alert_oe_out));
  tmr_host tmr_host_inst (.clk_in(core_clk_in), .wr_req_out(wr_req_in),
    .wr_first_out(wr_first_in), .wr_data_out(wr_data_in), .rd_req_out(rd_req_in),
    .alert_resp_out(alert_resp_in), .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out));
  // Live limit conditions from the model's held values
  function automatic logic [4:0] cond();
    logic signed [10:0] r, ru, rw;
    r = {ex[8'h01], ex[8'h10][7:5]};
    ru = {ex[8'h07], ex[8'h13][7:5]};
    rw = {ex[8'h08], ex[8'h14][7:5]};
    cond = {$signed(ex[0]) > $signed(ex[5]), $signed(ex[0]) < $signed(ex[6]), r > ru, r < rw, op};
  endfunction
  task automatic upd();
    mf = mf | cond();
    mal = mal | (|mf);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address 8'h20 as target means nothing is stored
  task automatic wrx(input logic [7:0] wa, input logic [7:0] ra, input logic [7:0] v);
    tmr_host_inst.wr(wa, v);
    if (ra != 8'h20) ex[ra] = v;
    upd();
  endtask
  task automatic rdc(input logic [7:0] a, input logic b);
    tmr_host_inst.setp(a);
    tmr_host_inst.rd(d);
    if (a == 8'h02) begin
      chk(d, {b, mf, 2'b00});
      mf = cond();
      mal = mal | (|mf);
    end else begin
      chk(d, ex[a]);
    end
  endtask
  task automatic chka();
    repeat (6) @(posedge core_clk_in);
    chk({7'h00, alert_n_out}, {7'h00, ~(mal & ~ex[3][7])});
    chk({7'h00, alert_oe_out}, {7'h00, mal & ~ex[3][7]});
  endtask
  task automatic rsp();
    tmr_host_inst.resp();
    if (mf == 5'h00 && cond() == 5'h00) mal = 1'b0;
  endtask
  task automatic sane();
    wrx(8'h0B, 8'h05, 8'h7F);
    wrx(8'h0C, 8'h06, 8'h80);
    wrx(8'h0D, 8'h07, 8'h7F);
    wrx(8'h13, 8'h13, 8'hE0);
    wrx(8'h0E, 8'h08, 8'h80);
    wrx(8'h14, 8'h14, 8'h00);
  endtask
  task automatic gap(output int k);
    k = 0;
    while (conv_start_out !== 1'b1 && k < 5000) begin
      @(posedge core_clk_in);
      k++;
    end
    @(posedge core_clk_in);
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Front end: answers each start after D cycles with the current sample
  always @(posedge core_clk_in) begin
    conv_done_in <= 1'b0;
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
    if (conv_start_out === 1'b1) begin
      fe_cnt = D;
      starts++;
    end else if (fe_cnt > 0) begin
      fe_cnt--;
      if (fe_cnt == 0) begin
        conv_done_in <= 1'b1;
        ex[0] = {1'b0, meas_in.local_raw};
        s = int'(meas_in.remote_raw) + int'($signed({ex[8'h11], ex[8'h12][7:5]}));
        if (s > 1023) s = 1023;
        if (s < -1024) s = -1024;
        ex[1] = s[10:3];
        ex[8'h10] = {s[2:0], 5'h00};
        op = meas_in.open_circuit;
        upd();
      end
    end
  end
  initial begin
    void'($urandom(32'h2492));
    foreach (ex[a]) ex[a] = 8'h00;
    {ex[0], ex[1], ex[4], ex[5], ex[6], ex[7], ex[8]} = {8'h80, 8'h80, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
    ex[8'hFE] = MID;
    ex[8'hFF] = REV;
    upd();
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    wrx(8'h09, 8'h03, 8'h40);
    repeat (30) @(posedge core_clk_in);
    for (int a = 0; a < 256; a++) rdc(8'(a), 1'b0);
    chka();
    wrx(8'h09, 8'h03, 8'hC0);
    chka();
    wrx(8'h09, 8'h03, 8'h40);
    for (int i = 0; i < 9; i++) begin
      wrx(wl[i], rl[i], 8'($urandom));
      rdc(rl[i], 1'b0);
    end
    wrx(8'h00, 8'h20, 8'($urandom));
    wrx(8'h01, 8'h20, 8'($urandom));
    wrx(8'h10, 8'h20, 8'($urandom));
    for (int a = 0; a < 3; a++) rdc(a == 2 ? 8'h10 : 8'(a), 1'b0);
    sane();
    st = starts;
    for (int i = 0; i < 10; i++) begin
      th = 8'($urandom);
      tl = 8'($urandom);
      rr = 10'($urandom);
      if (i == 0) {th, tl, rr} = {8'h7F, 8'hE0, 10'h3FF};
      if (i == 1) {th, tl, rr} = {8'h80, 8'h00, 10'h000};
      @(posedge core_clk_in);
      meas_in <= '{open_circuit: (i % 4 == 3), local_raw: 7'($urandom), remote_raw: rr};
      wrx(8'h11, 8'h11, th);
      wrx(8'h12, 8'h12, tl);
      wrx(8'h0F, 8'h20, 8'($urandom));
      rdc(8'h02, 1'b1);
      repeat (D + 8) @(posedge core_clk_in);
      for (int a = 0; a < 3; a++) rdc(a == 2 ? 8'h10 : 8'(a), 1'b0);
      rdc(8'h02, 1'b0);
    end
    repeat (700) @(posedge core_clk_in);
    chk(8'(starts - st), 8'h0A);
    rdc(8'h02, 1'b0);
    chka();
    r11 = {ex[1], ex[8'h10][7:5]};
    for (int k = 0; k < 2; k++) begin
      lim = r11 - 11'(k);
      wrx(8'h0D, 8'h07, lim[10:3]);
      wrx(8'h13, 8'h13, {lim[2:0], 5'h00});
      lim = r11 + 11'(k);
      wrx(8'h0E, 8'h08, lim[10:3]);
      wrx(8'h14, 8'h14, {lim[2:0], 5'h00});
      wrx(8'h0B, 8'h05, ex[0] - 8'(k));
      wrx(8'h0C, 8'h06, ex[0] + 8'(k));
      rdc(8'h02, 1'b0);
      rdc(8'h02, 1'b0);
    end
    sane();
    rdc(8'h02, 1'b0);
    rdc(8'h02, 1'b0);
    rsp();
    chka();
    @(posedge core_clk_in);
    sleep_request_pin_n_in <= 1'b0;
    // Pin must pass its synchroniser before run is selected, or a tick slips in
    repeat (6) @(posedge core_clk_in);
    wrx(8'h09, 8'h03, 8'h00);
    st = starts;
    repeat (300) @(posedge core_clk_in);
    chk(8'(starts - st), 8'h00);
    sleep_request_pin_n_in <= 1'b1;
    for (int c = 7; c > 5; c--) begin
      wrx(8'h0A, 8'h04, 8'(c));
      gap(n);
      gap(n);
      chk(8'(n + 1), 8'(BC << (7 - c)));
    end
    repeat (D + 4) @(posedge core_clk_in);
    wrx(8'h09, 8'h03, 8'h40);
    st = starts;
    meas_in <= '{open_circuit: 1'b0, local_raw: 7'h11, remote_raw: 10'h155};
    repeat (300) @(posedge core_clk_in);
    chk(8'(starts - st), 8'h00);
    for (int a = 0; a < 3; a++) rdc(a == 2 ? 8'h10 : 8'(a), 1'b0);
    stop_test();
  end
endmodule // tmr_regs_alert_test
`default_nettype wire
